//--- hdl/gpde_cfg.svh
// Register map, field positions and reset values of the port block
`ifndef GPDE_CFG_SVH
`define GPDE_CFG_SVH
`define GPDE_ADDR_W        8
`define GPDE_IDX_D_DATA    6'h03
`define GPDE_IDX_E_DATA    6'h08
`define GPDE_IDX_D_DIR     6'h10
`define GPDE_IDX_D_PUE     6'h11
`define GPDE_IDX_E_DIR     6'h12
`define GPDE_IDX_CTRL      6'h13
`define GPDE_D_DIR_RST     8'h00
`define GPDE_D_PUE_RST     8'h00
`define GPDE_E_DIR_RST     6'h00
`define GPDE_CTRL_RST      16'h0000
`define GPDE_RESP_OKAY     2'h0
`define GPDE_RESP_SLVERR   2'h2
`define GPDE_SPI_SS_PIN    0
`define GPDE_SPI_PIN_LO    1
`define GPDE_SPI_PIN_HI    3
`define GPDE_TIM_PIN_LO    4
`define GPDE_SCI_PIN_HI    1
`endif

//--- hdl/gpde_pkg.sv
// Types shared by the port block and its users
package gpde_pkg;
  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] oe;
  } gpde_drive_type;
  typedef struct packed {
    logic [7:0] edge_level_select;
    logic [4:0] spare;
    logic       serial_if_enable;
    logic       spi_master_select;
    logic       spi_enable_bit;
  } gpde_ctrl_type;
  typedef enum logic [0:0] {
    GPDE_WR_IDLE = 1'b0,
    GPDE_WR_RESP = 1'b1
  } gpde_wr_state_type;
endpackage

//--- hdl/gpde_ports.sv
// Ports D and E with peripheral overrides and an AXI4-Lite register slave
// Overview of operation
// - Port D has eight software read/write data latches that reset leaves untouched.
// - Port E has six software read/write data latches that reset leaves untouched.
// - A direction bit of 1 drives its pin, a direction bit of 0 makes it an input.
// - Reset clears all eight port D direction bits, so all its pins are inputs.
// - Reset clears all six port E direction bits, so all its pins are inputs.
// - Reading port D data gives the latch for output bits and the pin for input bits.
// - Reading port E data gives the latch for output bits and the pin for input bits.
// - Writing port data with byte lane 0 enabled updates the latch, and an input pin still reads its pin.
// - A port D pullup is on only while its enable is 1 and its direction bit is 0.
// - With the SPI disabled, its clock, MOSI and MISO pins are plain port D I/O.
// - The slave-select pin is plain I/O unless the SPI is enabled as a slave.
// - Pins in SPI use ignore the direction bits for drive but not for reads.
// - The upper port D pins follow the timer channels whose edge/level select is set.
// - With the serial interface disabled, its receive and transmit pins are plain I/O.
// - Pins in serial use ignore the direction bits for drive but not for reads.
`timescale 1ns/100ps
`include "gpde_cfg.svh"

module gpde_ports (
  // Clock, reset and clock enable
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // AXI4-Lite write address and data
  input  wire logic                     awvalid_i,
  output logic                          awready_o,
  input  wire logic [`GPDE_ADDR_W-1:0]  awaddr_i,
  input  wire logic [2:0]               awprot_i,
  input  wire logic                     wvalid_i,
  output logic                          wready_o,
  input  wire logic [31:0]              wdata_i,
  input  wire logic [3:0]               wstrb_i,
  // AXI4-Lite write response
  output logic                          bvalid_o,
  input  wire logic                     bready_i,
  output logic [1:0]                    bresp_o,
  // AXI4-Lite read
  input  wire logic                     arvalid_i,
  output logic                          arready_o,
  input  wire logic [`GPDE_ADDR_W-1:0]  araddr_i,
  input  wire logic [2:0]               arprot_i,
  output logic                          rvalid_o,
  input  wire logic                     rready_i,
  output logic [31:0]                   rdata_o,
  output logic [1:0]                    rresp_o,
  // Peripheral drive requests for port D and port E
  input  wire gpde_pkg::gpde_drive_type port_d_periph_i,
  input  wire gpde_pkg::gpde_drive_type port_e_periph_i,
  // Port D pins
  input  wire logic [7:0]               port_d_pin_i,
  output logic [7:0]                    port_d_pin_o,
  output logic [7:0]                    port_d_pin_oe_o,
  output logic [7:0]                    port_d_pullup_o,
  // Port E pins
  input  wire logic [5:0]               port_e_pin_i,
  output logic [5:0]                    port_e_pin_o,
  output logic [5:0]                    port_e_pin_oe_o,
  // Peripheral enables seen by the peripherals
  output logic                          spi_enable_bit_o,
  output logic                          spi_master_select_o,
  output logic                          serial_if_enable_o,
  output logic [7:0]                    edge_level_select_o
);
  import gpde_pkg::*;

  // Register state
  logic [7:0]        port_d_data_latch_reg;
  logic [5:0]        port_e_data_latch_reg;
  logic [7:0]        port_d_direction_reg;
  logic [7:0]        port_d_pullup_enable_reg;
  logic [5:0]        port_e_direction_reg;
  gpde_ctrl_type     ctrl_reg;

  // Bus state
  logic                    aw_hold_reg;
  logic [5:0]              aw_idx_reg;
  logic                    w_hold_reg;
  logic [7:0]              w_data_reg;
  logic                    w_lane0_reg;
  gpde_wr_state_type       wr_state_reg;
  gpde_wr_state_type       wr_state_next;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;

  // Lane 1 of a write, held until the write completes
  logic [7:0]              els_lane_reg;
  logic                    els_wr_reg;

  // Handshake decode
  wire        aw_take;
  wire        w_take;
  wire        wr_fire;
  wire        b_done;
  wire        ar_take;
  wire        r_done;
  wire [5:0]  ar_idx;
  wire        wr_d_data;
  wire        wr_e_data;
  wire        wr_d_dir;
  wire        wr_d_pue;
  wire        wr_e_dir;
  wire        wr_ctrl;
  wire        wr_hit;

  assign awready_o = ce_i & ~aw_hold_reg & (wr_state_reg == GPDE_WR_IDLE);
  assign wready_o  = ce_i & ~w_hold_reg & (wr_state_reg == GPDE_WR_IDLE);
  assign aw_take   = awvalid_i & awready_o;
  assign w_take    = wvalid_i & wready_o;
  assign wr_fire   = ce_i & aw_hold_reg & w_hold_reg &
                     (wr_state_reg == GPDE_WR_IDLE);
  assign bvalid_o  = ce_i & (wr_state_reg == GPDE_WR_RESP);
  assign b_done    = bvalid_o & bready_i;
  assign bresp_o   = bresp_reg;

  assign arready_o = ce_i & ~rvalid_reg;
  assign ar_take   = arvalid_i & arready_o;
  assign rvalid_o  = ce_i & rvalid_reg;
  assign r_done    = rvalid_o & rready_i;
  assign rdata_o   = rdata_reg;
  assign rresp_o   = rresp_reg;
  assign ar_idx    = araddr_i[`GPDE_ADDR_W-1:2];

  // Register select on a completed write, lane 0 carries every field except the edge/level selects in lane 1
  assign wr_d_data = wr_fire & w_lane0_reg &
                     (aw_idx_reg == `GPDE_IDX_D_DATA);
  assign wr_e_data = wr_fire & w_lane0_reg &
                     (aw_idx_reg == `GPDE_IDX_E_DATA);
  assign wr_d_dir  = wr_fire & w_lane0_reg &
                     (aw_idx_reg == `GPDE_IDX_D_DIR);
  assign wr_d_pue  = wr_fire & w_lane0_reg &
                     (aw_idx_reg == `GPDE_IDX_D_PUE);
  assign wr_e_dir  = wr_fire & w_lane0_reg &
                     (aw_idx_reg == `GPDE_IDX_E_DIR);
  assign wr_ctrl   = wr_fire & (aw_idx_reg == `GPDE_IDX_CTRL);
  assign wr_hit    = (aw_idx_reg == `GPDE_IDX_D_DATA) |
                     (aw_idx_reg == `GPDE_IDX_E_DATA) |
                     (aw_idx_reg == `GPDE_IDX_D_DIR)  |
                     (aw_idx_reg == `GPDE_IDX_D_PUE)  |
                     (aw_idx_reg == `GPDE_IDX_E_DIR)  |
                     (aw_idx_reg == `GPDE_IDX_CTRL);

  // Peripheral ownership of pins
  wire [7:0]  d_spi_use;
  wire [7:0]  d_tim_use;
  wire [7:0]  d_periph_use;
  wire [5:0]  e_sci_use;
  wire [3:0]  tim_chan_on;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_tim
      // Either edge/level select bit hands the pin to the channel
      assign tim_chan_on[ch] = |ctrl_reg.edge_level_select[2*ch+1:2*ch];
    end
  endgenerate

  assign d_spi_use[`GPDE_SPI_SS_PIN] = ctrl_reg.spi_enable_bit &
                                       ~ctrl_reg.spi_master_select;
  assign d_spi_use[`GPDE_SPI_PIN_HI:`GPDE_SPI_PIN_LO] =
    {3{ctrl_reg.spi_enable_bit}};
  assign d_spi_use[7:4] = 4'h0;
  assign d_tim_use = {tim_chan_on, 4'h0};
  assign d_periph_use = d_spi_use | d_tim_use;
  assign e_sci_use = {4'h0, {2{ctrl_reg.serial_if_enable}}};

  // Pin drive: peripheral owns drive, otherwise direction and latch
  assign port_d_pin_oe_o = (d_periph_use & port_d_periph_i.oe) |
                           (~d_periph_use & port_d_direction_reg);
  assign port_d_pin_o    = (d_periph_use & port_d_periph_i.dat) |
                           (~d_periph_use & port_d_data_latch_reg);
  assign port_e_pin_oe_o = (e_sci_use & port_e_periph_i.oe[5:0]) |
                           (~e_sci_use & port_e_direction_reg);
  assign port_e_pin_o    = (e_sci_use & port_e_periph_i.dat[5:0]) |
                           (~e_sci_use & port_e_data_latch_reg);

  // Pullup only on pins configured as inputs
  assign port_d_pullup_o = port_d_pullup_enable_reg &
                           ~port_d_direction_reg;

  assign spi_enable_bit_o    = ctrl_reg.spi_enable_bit;
  assign spi_master_select_o = ctrl_reg.spi_master_select;
  assign serial_if_enable_o  = ctrl_reg.serial_if_enable;
  assign edge_level_select_o = ctrl_reg.edge_level_select;

  // Port reads: direction bit picks latch or pin, whoever drives
  wire [7:0]  d_read;
  wire [5:0]  e_read;
  wire [31:0] rd_mux;
  wire        rd_hit;

  assign d_read = (port_d_direction_reg & port_d_data_latch_reg) |
                  (~port_d_direction_reg & port_d_pin_i);
  assign e_read = (port_e_direction_reg & port_e_data_latch_reg) |
                  (~port_e_direction_reg & port_e_pin_i);

  assign rd_hit = (ar_idx == `GPDE_IDX_D_DATA) |
                  (ar_idx == `GPDE_IDX_E_DATA) |
                  (ar_idx == `GPDE_IDX_D_DIR)  |
                  (ar_idx == `GPDE_IDX_D_PUE)  |
                  (ar_idx == `GPDE_IDX_E_DIR)  |
                  (ar_idx == `GPDE_IDX_CTRL);

  assign rd_mux =
    (ar_idx == `GPDE_IDX_D_DATA) ? {24'h000000, d_read} :
    (ar_idx == `GPDE_IDX_E_DATA) ? {26'h0000000, e_read} :
    (ar_idx == `GPDE_IDX_D_DIR)  ? {24'h000000, port_d_direction_reg} :
    (ar_idx == `GPDE_IDX_D_PUE)  ? {24'h000000, port_d_pullup_enable_reg} :
    (ar_idx == `GPDE_IDX_E_DIR)  ? {26'h0000000, port_e_direction_reg} :
    (ar_idx == `GPDE_IDX_CTRL)   ? {16'h0000, ctrl_reg} :
                                   32'h00000000;

  // Write response state
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      GPDE_WR_IDLE: begin
        if (wr_fire) begin
          wr_state_next = GPDE_WR_RESP;
        end
      end
      GPDE_WR_RESP: begin
        if (b_done) begin
          wr_state_next = GPDE_WR_IDLE;
        end
      end
      default: begin
        wr_state_next = GPDE_WR_IDLE;
      end
    endcase
  end

  // Address and data capture, either order
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg  <= 1'b0;
      aw_idx_reg   <= 6'h00;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_lane0_reg  <= 1'b0;
      wr_state_reg <= GPDE_WR_IDLE;
      bresp_reg    <= `GPDE_RESP_OKAY;
    end else if (ce_i) begin
      wr_state_reg <= wr_state_next;
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg  <= awaddr_i[`GPDE_ADDR_W-1:2];
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg  <= 1'b1;
        w_data_reg  <= wdata_i[7:0];
        w_lane0_reg <= wstrb_i[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_fire) begin
        bresp_reg <= wr_hit ? `GPDE_RESP_OKAY : `GPDE_RESP_SLVERR;
      end
    end
  end

  // Read channel
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `GPDE_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_hit ? `GPDE_RESP_OKAY : `GPDE_RESP_SLVERR;
      end else if (r_done) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Direction, pullup and peripheral control registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_d_direction_reg     <= `GPDE_D_DIR_RST;
      port_e_direction_reg     <= `GPDE_E_DIR_RST;
      port_d_pullup_enable_reg <= `GPDE_D_PUE_RST;
      ctrl_reg                 <= `GPDE_CTRL_RST;
    end else if (ce_i) begin
      if (wr_d_dir) begin
        port_d_direction_reg <= w_data_reg;
      end
      if (wr_e_dir) begin
        port_e_direction_reg <= w_data_reg[5:0];
      end
      if (wr_d_pue) begin
        port_d_pullup_enable_reg <= w_data_reg;
      end
      if (wr_ctrl && w_lane0_reg) begin
        ctrl_reg.spare             <= 5'h00;
        ctrl_reg.serial_if_enable  <= w_data_reg[2];
        ctrl_reg.spi_master_select <= w_data_reg[1];
        ctrl_reg.spi_enable_bit    <= w_data_reg[0];
      end
      // Lane 1 of the control word carries the edge/level selects
      if (wr_ctrl && els_wr_reg) begin
        ctrl_reg.edge_level_select <= els_lane_reg;
      end
    end
  end

  // Edge/level select sits in byte lane 1 of the control register,
  // captured with the write data and applied when the write completes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      els_lane_reg <= 8'h00;
      els_wr_reg   <= 1'b0;
    end else if (ce_i) begin
      if (w_take) begin
        els_lane_reg <= wdata_i[15:8];
        els_wr_reg   <= wstrb_i[1];
      end
    end
  end

  // Data latches keep their contents through reset
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      if (wr_d_data) begin
        port_d_data_latch_reg <= w_data_reg;
      end
      if (wr_e_data) begin
        port_e_data_latch_reg <= w_data_reg[5:0];
      end
    end
  end

endmodule // gpde_ports

//--- bench/gpde_ports_properties.sv
// Concurrent checks on the port block's outputs
`timescale 1ns/100ps
module gpde_ports_properties (
  // Clock and reset
  input wire logic                     core_clk_i, rst_n_i,
  // Register bus handshakes
  input wire logic                     awvalid_i, awready_o, wvalid_i,
  input wire logic                     wready_o, bvalid_o, bready_i,
  input wire logic                     arvalid_i, arready_o, rvalid_o,
  input wire logic                     rready_i,
  input wire logic [31:0]              rdata_o,
  // Peripheral requests and pins
  input wire gpde_pkg::gpde_drive_type port_d_periph_i, port_e_periph_i,
  input wire logic [7:0]               port_d_pin_oe_o, port_d_pullup_o,
  input wire logic [5:0]               port_e_pin_oe_o,
  // Peripheral enables
  input wire logic                     spi_enable_bit_o, spi_master_select_o,
  input wire logic                     serial_if_enable_o,
  input wire logic [7:0]               edge_level_select_o
);
  import gpde_pkg::*;
  logic [7:0] els;
  logic [7:0] d_own;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Pins handed to the timer channels and the SPI
  assign els = edge_level_select_o;
  assign d_own = {|els[7:6], |els[5:4], |els[3:2], |els[1:0],
                  {3{spi_enable_bit_o}},
                  spi_enable_bit_o & ~spi_master_select_o};
  a_pullup_input: assert property (
    (port_d_pullup_o & port_d_pin_oe_o & ~d_own) == 8'h00)
    else $error("pullup on while pin drives");
  a_d_periph_own: assert property (
    ((port_d_pin_oe_o ^ port_d_periph_i.oe) & d_own) == 8'h00)
    else $error("owned port D pin not driven by peripheral");
  a_e_serial_own: assert property (
    serial_if_enable_o |-> port_e_pin_oe_o[1:0] == port_e_periph_i.oe[1:0])
    else $error("serial pins not driven by peripheral");
  a_reset_inputs: assert property (
    $rose(rst_n_i) |-> {port_d_pin_oe_o, port_e_pin_oe_o} == 14'h0000)
    else $error("pins not inputs after reset");
  a_write_resp: assert property (
    awvalid_i && awready_o && wvalid_i && wready_o |=> !bvalid_o ##1 bvalid_o)
    else $error("write response not two cycles after taking");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o)
    else $error("write response dropped early");
  a_no_new_write: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write taken while response pending");
  a_rdata_hold: assert property (
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data not held");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read answer late");
  a_read_block: assert property (rvalid_o |-> !arready_o)
    else $error("read address taken while data pending");
endmodule // gpde_ports_properties
bind gpde_ports gpde_ports_properties u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .awvalid_i(awvalid_i),
  .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o),
  .bvalid_o(bvalid_o), .bready_i(bready_i), .arvalid_i(arvalid_i),
  .arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
  .rdata_o(rdata_o), .port_d_periph_i(port_d_periph_i),
  .port_e_periph_i(port_e_periph_i), .port_d_pin_oe_o(port_d_pin_oe_o),
  .port_d_pullup_o(port_d_pullup_o), .port_e_pin_oe_o(port_e_pin_oe_o),
  .spi_enable_bit_o(spi_enable_bit_o),
  .spi_master_select_o(spi_master_select_o),
  .serial_if_enable_o(serial_if_enable_o),
  .edge_level_select_o(edge_level_select_o));

//--- bench/gpde_pins_model.sv
// Pad model for the pins of ports D and E
`timescale 1ns/100ps
module gpde_pins_model #(
  parameter int W = 8
) (
  // Clock for the floating-pin pattern
  input  wire logic         clk_i,
  // Drive from the block and from outside
  input  wire logic [W-1:0] pin_o_i, oe_i, pu_i, ext_en_i, ext_val_i,
  // Resolved pin level
  output logic [W-1:0]      level_o
);
  logic [W-1:0] flt_reg;
  initial flt_reg = '0;
  // Undriven pins without pullup toggle so no stale level is read
  always @(posedge clk_i) flt_reg <= ~flt_reg;
  assign level_o = oe_i & pin_o_i
                 | ~oe_i & ext_en_i & ext_val_i
                 | ~oe_i & ~ext_en_i & pu_i
                 | ~oe_i & ~ext_en_i & ~pu_i & flt_reg;
endmodule // gpde_pins_model

//--- bench/gpde_ports_tb.sv
// Self-checking bench for ports D and E
`timescale 1ns/100ps
`include "gpde_cfg.svh"
module gpde_ports_tb;
  import gpde_pkg::*;
  localparam logic [7:0] AD  = {`GPDE_IDX_D_DATA, 2'b00};
  localparam logic [7:0] AE  = {`GPDE_IDX_E_DATA, 2'b00};
  localparam logic [7:0] ADR = {`GPDE_IDX_D_DIR, 2'b00};
  localparam logic [7:0] APU = {`GPDE_IDX_D_PUE, 2'b00};
  localparam logic [7:0] AER = {`GPDE_IDX_E_DIR, 2'b00};
  localparam logic [7:0] ACT = {`GPDE_IDX_CTRL, 2'b00};
  logic core_clk_i, rst_n_i, ce_i, awvalid_i, awready_o, wvalid_i, wready_o;
  logic bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
  logic spi_enable_bit_o, spi_master_select_o, serial_if_enable_o;
  logic [7:0] awaddr_i, araddr_i, edge_level_select_o, d_ext, d_xv;
  logic [7:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe_o, port_d_pullup_o;
  logic [5:0] port_e_pin_i, port_e_pin_o, port_e_pin_oe_o, e_ext, e_xv;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wstrb_i;
  logic [2:0] awprot_i, arprot_i;
  logic [1:0] bresp_o, rresp_o, rsp;
  gpde_drive_type port_d_periph_i, port_e_periph_i;
  int err_count, n_checks;
  gpde_ports DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .awprot_i(awprot_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .araddr_i(araddr_i), .arprot_i(arprot_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .port_d_periph_i(port_d_periph_i),
    .port_e_periph_i(port_e_periph_i), .port_d_pin_i(port_d_pin_i),
    .port_d_pin_o(port_d_pin_o), .port_d_pin_oe_o(port_d_pin_oe_o),
    .port_d_pullup_o(port_d_pullup_o), .port_e_pin_i(port_e_pin_i),
    .port_e_pin_o(port_e_pin_o), .port_e_pin_oe_o(port_e_pin_oe_o),
    .spi_enable_bit_o(spi_enable_bit_o),
    .spi_master_select_o(spi_master_select_o),
    .serial_if_enable_o(serial_if_enable_o),
    .edge_level_select_o(edge_level_select_o));
  gpde_pins_model #(.W(8)) u_pd (.clk_i(core_clk_i), .pin_o_i(port_d_pin_o),
    .oe_i(port_d_pin_oe_o), .pu_i(port_d_pullup_o), .ext_en_i(d_ext),
    .ext_val_i(d_xv), .level_o(port_d_pin_i));
  gpde_pins_model #(.W(6)) u_pe (.clk_i(core_clk_i), .pin_o_i(port_e_pin_o),
    .oe_i(port_e_pin_oe_o), .pu_i(6'h00), .ext_en_i(e_ext),
    .ext_val_i(e_xv), .level_o(port_e_pin_i));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    do begin
      @(negedge core_clk_i);
      ta = awvalid_i & awready_o;
      tw = wvalid_i & wready_o;
      @(posedge core_clk_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
    end while (awvalid_i & ~ta | wvalid_i & ~tw);
    do @(negedge core_clk_i); while (!bvalid_o);
    @(posedge core_clk_i);
    bready_i <= 1'b1;
    @(negedge core_clk_i);
    rsp = bresp_o;
    @(posedge core_clk_i);
    bready_i <= 1'b0;
  endtask
  // Reads a register and compares response code and data together
  task automatic rc(input logic [7:0] a, input logic [33:0] e);
    logic t;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    do begin
      @(negedge core_clk_i);
      t = arready_o;
      @(posedge core_clk_i);
    end while (!t);
    arvalid_i <= 1'b0;
    do @(negedge core_clk_i); while (!rvalid_o);
    @(posedge core_clk_i);
    rready_i <= 1'b1;
    @(negedge core_clk_i);
    chk({rresp_o, rdata_o}, e);
    @(posedge core_clk_i);
    rready_i <= 1'b0;
  endtask
  task automatic t_rst();
    rc(ADR, 32'h0);
    rc(AER, 32'h0);
    chk({port_d_pin_oe_o, port_e_pin_oe_o}, 14'h0);
  endtask
  task automatic t_pd();
    d_ext <= 8'hFF;
    d_xv <= 8'h3C;
    wr(AD, 32'hA5);
    chk(rsp, `GPDE_RESP_OKAY);
    rc(AD, 32'h3C);
    wr(ADR, 32'hF0);
    rc(AD, 32'hAC);
    chk({port_d_pin_oe_o, port_d_pin_o[7:4]}, 12'hF0A);
    wr(APU, 32'hFF);
    chk(port_d_pullup_o, 8'h0F);
    d_ext <= 8'h00;
    wr(ADR, 32'h0);
    rc(AD, 32'hFF);
  endtask
  task automatic t_pe();
    e_ext <= 6'h3F;
    e_xv <= 6'h15;
    wr(AE, 32'h2A);
    wr(AER, 32'h07);
    rc(AE, 32'h12);
    chk({port_e_pin_oe_o, port_e_pin_o[2:0]}, 9'h03A);
  endtask
  task automatic t_keep();
    wr(ADR, 32'hFF);
    rst_n_i <= 1'b0;
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    chk({port_d_pin_oe_o, port_e_pin_oe_o}, 14'h0);
    rc(ADR, 32'h0);
    rc(AER, 32'h0);
    wr(ADR, 32'hFF);
    wr(AER, 32'h3F);
    rc(AD, 32'hA5);
    rc(AE, 32'h2A);
  endtask
  task automatic t_own();
    logic [15:0] cv [7] = '{16'h0, 16'h1, 16'h3, 16'h100, 16'h800,
                            16'h1000, 16'h8000};
    logic [7:0] mv [7] = '{8'h0, 8'h0F, 8'h0E, 8'h10, 8'h20, 8'h40, 8'h80};
    port_d_periph_i <= '{dat: 8'h5A, oe: 8'hC3};
    port_e_periph_i <= '{dat: 8'h01, oe: 8'h01};
    for (int i = 0; i < 7; i++) begin
      wr(ACT, {16'h0, cv[i]});
      chk({port_d_pin_oe_o, port_d_pin_o}, {~mv[i] | 8'hC3 & mv[i],
          8'hA5 & ~mv[i] | 8'h5A & mv[i]});
      chk({spi_enable_bit_o, spi_master_select_o, edge_level_select_o},
          {cv[i][0], cv[i][1], cv[i][15:8]});
      rc(ACT, {16'h0, cv[i]});
      rc(AD, 32'hA5);
    end
    wr(ACT, 32'h4);
    chk({port_e_pin_oe_o, port_e_pin_o}, {6'h3D, 6'h29});
    chk(serial_if_enable_o, 1'b1);
    rc(AE, 32'h2A);
    wr(ACT, 32'h0);
    chk({port_e_pin_oe_o, port_e_pin_o}, {6'h3F, 6'h2A});
  endtask
  task automatic t_bad();
    wr(8'h7C, 32'h1);
    chk(rsp, `GPDE_RESP_SLVERR);
    rc(8'h7C, {`GPDE_RESP_SLVERR, 32'h0});
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {awaddr_i, araddr_i, wdata_i, awprot_i, arprot_i} = '0;
    {d_ext, d_xv, e_ext, e_xv, port_d_periph_i, port_e_periph_i} = '0;
    ce_i = 1'b1;
    wstrb_i = 4'hF;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_rst();
    t_pd();
    t_pe();
    t_keep();
    t_own();
    t_bad();
    conclude();
  end
  initial begin
    #500000;
    err_count++;
    conclude();
  end
endmodule // gpde_ports_tb
